/* File: src/mb_frame_pkg.sv */
/*
  constants, types and the crc step for the modbus rtu frame engine.
  assumes a byte-wide serial port (uart) on the same clock outside the engine.
*/
package mb_frame_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h04;
  localparam logic [7:0] OFS_BIT_DIV = 8'h08;
  localparam logic [7:0] OFS_EOF_EXTRA = 8'h0c;
  localparam logic [7:0] OFS_RSP_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_RETRIES = 8'h14;
  localparam logic [7:0] OFS_REQ_ADDR = 8'h18;
  localparam logic [7:0] OFS_REQ_FC = 8'h1c;
  localparam logic [7:0] OFS_REQ_START = 8'h20;
  localparam logic [7:0] OFS_REQ_QTY = 8'h24;
  localparam logic [7:0] OFS_FILL = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2c;
  localparam logic [7:0] OFS_LAST_REQ = 8'h30;
  localparam logic [7:0] OFS_EVENT_CNT = 8'h34;
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_START = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_NEW = 3;
  localparam logic [15:0] BIT_DIV_RST = 16'h01b2;
  localparam logic [15:0] RSP_TIMEOUT_RST = 16'h2710;
  localparam logic [3:0] RETRIES_RST = 4'h2;
  // ****************************************
  // protocol constants
  // ****************************************
  localparam logic [8:0] EOF_BASE_BITS = 9'h023;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
  localparam logic [7:0] FC_RD_COILS = 8'h01, FC_RD_INPUTS = 8'h02, FC_RD_HOLD = 8'h03, FC_RD_INREG = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05, FC_WR_REG = 8'h06, FC_DIAG = 8'h08, FC_EVT_CNT = 8'h0b;
  localparam logic [7:0] FC_EVT_LOG = 8'h0c, FC_WR_COILS = 8'h0f, FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01, EXC_ILL_ADDR = 8'h02, EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] EXC_DEV_FAIL = 8'h04, EXC_ACK = 8'h05, EXC_BUSY = 8'h06, EXC_NAK = 8'h07;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [15:0] DIAG_CLR_CNT = 16'h000a;
  localparam logic [15:0] MAX_RD_BITS = 16'h07d0, MAX_RD_WORDS = 16'h007d, MAX_RD_WORDS_EXT = 16'h007c;
  localparam logic [15:0] MAX_WR_BITS = 16'h07b0, MAX_WR_WORDS = 16'h007b;
  localparam logic [15:0] COIL_ON = 16'hff00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_WAIT = 2'b10
  } st_t;

  // one byte through the reflected crc, lsb first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  // quantity limits per function code
  function automatic logic qty_ok(input logic [7:0] fc, input logic [15:0] qty, input logic ext);
    logic ok;
    ok = 1'b1;
    case (fc)
      FC_RD_COILS, FC_RD_INPUTS: ok = (qty != 16'h0000) && (qty <= MAX_RD_BITS);
      FC_RD_HOLD, FC_RD_INREG: ok = (qty != 16'h0000) && (qty <= (ext ? MAX_RD_WORDS_EXT : MAX_RD_WORDS));
      FC_WR_COIL: ok = (qty == COIL_ON) || (qty == 16'h0000);
      FC_WR_COILS: ok = (qty != 16'h0000) && (qty <= MAX_WR_BITS);
      FC_WR_REGS: ok = (qty != 16'h0000) && (qty <= MAX_WR_WORDS);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction
endpackage

/* File: src/modbus_rtu_frame_engine.sv */
/*
  modbus rtu frame engine: master request/response with retries, slave answer with exceptions.
  assumes a uart on clk_i that hands in received bytes as one-cycle pulses and takes bytes by valid/ready.
*/
`timescale 1ns/1ns
module modbus_rtu_frame_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    mb_frame_pkg::st_t st;
    logic master;
    logic ext;
    logic [15:0] own;
    logic [15:0] div;
    logic [7:0] extra;
    logic [15:0] tmo;
    logic [3:0] retries;
    logic [15:0] req_addr;
    logic [7:0] req_fc;
    logic [15:0] req_start;
    logic [15:0] req_qty;
    logic [7:0] fill;
    logic done;
    logic err;
    logic new_req;
    logic [7:0] exc;
    logic [7:0] last_fc;
    logic [15:0] last_start;
    logic [15:0] evcnt;
    logic [3:0] tries;
    logic [15:0] bit_cnt;
    logic [8:0] sil;
    logic [15:0] wait_cnt;
    logic [8:0] rx_cnt;
    logic [7:0][7:0] rbuf;
    logic [15:0] rcrc;
    logic [7:0][7:0] tbuf;
    logic [3:0] tlen;
    logic [7:0] tfill;
    logic [8:0] tidx;
    logic [15:0] tcrc;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t next_q;

  logic [2:0] hl;
  logic [15:0] rx_adr;
  logic [7:0] rx_fc;
  logic [15:0] rx_start;
  logic [15:0] rx_qty;
  logic [8:0] sil_lim;
  logic tick;
  logic eof;
  logic good;
  logic [7:0] tx_byte;
  logic [8:0] fill_end;

  // ****************************************
  // frame fields and timing
  // ****************************************
  always_comb begin
    hl = q.ext ? 3'h2 : 3'h1;
    rx_adr = q.ext ? {q.rbuf[0], q.rbuf[1]} : {8'h00, q.rbuf[0]};
    rx_fc = q.rbuf[hl];
    rx_start = {q.rbuf[3'(hl + 3'h1)], q.rbuf[3'(hl + 3'h2)]};
    rx_qty = {q.rbuf[3'(hl + 3'h3)], q.rbuf[3'(hl + 3'h4)]};
    sil_lim = mb_frame_pkg::EOF_BASE_BITS + {1'b0, q.extra};
    tick = (q.bit_cnt + 16'h0001 >= q.div);
    eof = (q.rx_cnt != 9'h000) && (q.sil >= sil_lim);
    // residue over data and crc is zero when the check matches
    good = eof && (q.rcrc == 16'h0000) && (q.rx_cnt >= 9'({6'h00, hl} + 9'h003));
    fill_end = {5'h00, q.tlen} + {1'b0, q.tfill};
    if (q.tidx < {5'h00, q.tlen}) begin
      tx_byte = q.tbuf[q.tidx[2:0]];
    end else if (q.tidx < fill_end) begin
      tx_byte = q.fill;
    end else if (q.tidx == fill_end) begin
      tx_byte = q.tcrc[7:0];
    end else begin
      tx_byte = q.tcrc[15:8];
    end
  end

  assign tx_valid_o = (q.st == mb_frame_pkg::ST_SEND);
  assign tx_data_o = tx_byte;
  assign rdata_o = q.rdata;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic c_go;
    logic [15:0] c_adr;
    logic [7:0] c_fc;
    logic [15:0] c_a;
    logic [15:0] c_b;
    logic [2:0] c_kind;
    logic [7:0] c_cnt;
    logic [7:0] exc;
    logic bc;
    logic wr_fc;
    logic [2:0] p;
    c_go = 1'b0;
    c_adr = 16'h0000;
    c_fc = 8'h00;
    c_a = 16'h0000;
    c_b = 16'h0000;
    c_kind = 3'h0;
    c_cnt = 8'h00;
    exc = mb_frame_pkg::EXC_NONE;
    bc = 1'b0;
    wr_fc = 1'b0;
    p = 3'h0;
    next_q = q;
    next_q.bit_cnt = tick ? 16'h0000 : q.bit_cnt + 16'h0001;

    // register port
    if (rd_i) begin
      case (addr_i)
        mb_frame_pkg::OFS_CTRL: next_q.rdata = {30'h0, q.ext, q.master};
        mb_frame_pkg::OFS_OWN_ADDR: next_q.rdata = {16'h0, q.own};
        mb_frame_pkg::OFS_BIT_DIV: next_q.rdata = {16'h0, q.div};
        mb_frame_pkg::OFS_EOF_EXTRA: next_q.rdata = {24'h0, q.extra};
        mb_frame_pkg::OFS_RSP_TIMEOUT: next_q.rdata = {16'h0, q.tmo};
        mb_frame_pkg::OFS_RETRIES: next_q.rdata = {28'h0, q.retries};
        mb_frame_pkg::OFS_REQ_ADDR: next_q.rdata = {16'h0, q.req_addr};
        mb_frame_pkg::OFS_REQ_FC: next_q.rdata = {24'h0, q.req_fc};
        mb_frame_pkg::OFS_REQ_START: next_q.rdata = {16'h0, q.req_start};
        mb_frame_pkg::OFS_REQ_QTY: next_q.rdata = {16'h0, q.req_qty};
        mb_frame_pkg::OFS_FILL: next_q.rdata = {24'h0, q.fill};
        mb_frame_pkg::OFS_STATUS: next_q.rdata = {16'h0, q.exc, 4'h0, q.new_req, q.err, q.done, q.st != mb_frame_pkg::ST_IDLE};
        mb_frame_pkg::OFS_LAST_REQ: next_q.rdata = {8'h0, q.last_fc, q.last_start};
        mb_frame_pkg::OFS_EVENT_CNT: next_q.rdata = {16'h0, q.evcnt};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_i) begin
      case (addr_i)
        mb_frame_pkg::OFS_CTRL: begin
          if (q.st == mb_frame_pkg::ST_IDLE) begin
            next_q.master = wdata_i[mb_frame_pkg::CTRL_MASTER];
            next_q.ext = wdata_i[mb_frame_pkg::CTRL_EXT];
          end
        end
        mb_frame_pkg::OFS_OWN_ADDR: next_q.own = wdata_i[15:0];
        mb_frame_pkg::OFS_BIT_DIV: next_q.div = wdata_i[15:0];
        mb_frame_pkg::OFS_EOF_EXTRA: next_q.extra = wdata_i[7:0];
        mb_frame_pkg::OFS_RSP_TIMEOUT: next_q.tmo = wdata_i[15:0];
        mb_frame_pkg::OFS_RETRIES: next_q.retries = wdata_i[3:0];
        mb_frame_pkg::OFS_REQ_ADDR: next_q.req_addr = wdata_i[15:0];
        mb_frame_pkg::OFS_REQ_FC: next_q.req_fc = wdata_i[7:0];
        mb_frame_pkg::OFS_REQ_START: next_q.req_start = wdata_i[15:0];
        mb_frame_pkg::OFS_REQ_QTY: next_q.req_qty = wdata_i[15:0];
        mb_frame_pkg::OFS_FILL: next_q.fill = wdata_i[7:0];
        mb_frame_pkg::OFS_STATUS: begin
          // write one to clear; hardware sets below win
          if (wdata_i[mb_frame_pkg::STAT_DONE]) next_q.done = 1'b0;
          if (wdata_i[mb_frame_pkg::STAT_ERR]) next_q.err = 1'b0;
          if (wdata_i[mb_frame_pkg::STAT_NEW]) next_q.new_req = 1'b0;
        end
        default: ;
      endcase
    end

    // silence timer
    if (tick && q.rx_cnt != 9'h000 && q.sil < sil_lim) begin
      next_q.sil = q.sil + 9'h001;
    end
    if (eof) begin
      next_q.rx_cnt = 9'h000;
      next_q.sil = 9'h000;
    end

    case (q.st)
      mb_frame_pkg::ST_IDLE: begin
        // master start
        if (wr_i && addr_i == mb_frame_pkg::OFS_CTRL && wdata_i[mb_frame_pkg::CTRL_START] && q.master) begin
          bc = (q.req_addr == 16'h0000);
          wr_fc = (q.req_fc == mb_frame_pkg::FC_WR_COIL) || (q.req_fc == mb_frame_pkg::FC_WR_REG) ||
                  (q.req_fc == mb_frame_pkg::FC_WR_COILS) || (q.req_fc == mb_frame_pkg::FC_WR_REGS);
          case (q.req_fc)
            mb_frame_pkg::FC_RD_COILS, mb_frame_pkg::FC_RD_INPUTS, mb_frame_pkg::FC_RD_HOLD, mb_frame_pkg::FC_RD_INREG,
            mb_frame_pkg::FC_WR_COIL, mb_frame_pkg::FC_WR_REG, mb_frame_pkg::FC_DIAG: c_kind = 3'h1;
            mb_frame_pkg::FC_EVT_CNT, mb_frame_pkg::FC_EVT_LOG: c_kind = 3'h0;
            mb_frame_pkg::FC_WR_COILS, mb_frame_pkg::FC_WR_REGS: c_kind = 3'h2;
            default: exc = mb_frame_pkg::EXC_ILL_FUNC;
          endcase
          if ((bc && !wr_fc) || (q.ext && q.req_addr == 16'h0000 && !wr_fc)) begin
            exc = mb_frame_pkg::EXC_ILL_FUNC;
          end
          if (!mb_frame_pkg::qty_ok(q.req_fc, q.req_qty, q.ext)) begin
            exc = mb_frame_pkg::EXC_ILL_VALUE;
          end
          next_q.done = 1'b0;
          next_q.err = 1'b0;
          next_q.tries = 4'h0;
          if (exc != mb_frame_pkg::EXC_NONE) begin
            next_q.done = 1'b1;
            next_q.err = 1'b1;
            next_q.exc = exc;
          end else begin
            next_q.exc = mb_frame_pkg::EXC_NONE;
            c_go = 1'b1;
            c_adr = q.req_addr;
            c_fc = q.req_fc;
            c_a = q.req_start;
            c_b = q.req_qty;
          end
        end else if (good && !q.master) begin
          // slave evaluation after silence
          bc = (rx_adr == 16'h0000);
          wr_fc = (rx_fc == mb_frame_pkg::FC_WR_COIL) || (rx_fc == mb_frame_pkg::FC_WR_REG) ||
                  (rx_fc == mb_frame_pkg::FC_WR_COILS) || (rx_fc == mb_frame_pkg::FC_WR_REGS);
          case (rx_fc)
            mb_frame_pkg::FC_RD_COILS, mb_frame_pkg::FC_RD_INPUTS: begin
              c_kind = 3'h3;
              c_cnt = 8'((rx_qty + 16'h0007) >> 3);
            end
            mb_frame_pkg::FC_RD_HOLD, mb_frame_pkg::FC_RD_INREG: begin
              c_kind = 3'h3;
              c_cnt = 8'(rx_qty << 1);
            end
            mb_frame_pkg::FC_WR_COIL, mb_frame_pkg::FC_WR_REG, mb_frame_pkg::FC_WR_COILS,
            mb_frame_pkg::FC_WR_REGS, mb_frame_pkg::FC_DIAG: c_kind = 3'h1;
            default: exc = mb_frame_pkg::EXC_ILL_FUNC;
          endcase
          if (exc == mb_frame_pkg::EXC_NONE && !mb_frame_pkg::qty_ok(rx_fc, rx_qty, q.ext)) begin
            exc = mb_frame_pkg::EXC_ILL_VALUE;
          end
          if ((rx_adr == q.own && rx_adr != 16'h0000) || (bc && wr_fc)) begin
            next_q.last_fc = rx_fc;
            next_q.last_start = rx_start;
            if (exc == mb_frame_pkg::EXC_NONE) begin
              next_q.new_req = 1'b1;
              next_q.evcnt = q.evcnt + 16'h0001;
              if (rx_fc == mb_frame_pkg::FC_DIAG && rx_start == mb_frame_pkg::DIAG_CLR_CNT) begin
                next_q.evcnt = 16'h0000;
              end
            end else begin
              c_kind = 3'h4;
            end
            c_go = !bc;
            c_adr = rx_adr;
            c_fc = rx_fc;
            c_a = rx_start;
            c_b = rx_qty;
          end
        end
      end
      mb_frame_pkg::ST_SEND: begin
        if (tx_ready_i) begin
          if (q.tidx < fill_end) begin
            next_q.tcrc = mb_frame_pkg::crc_step(q.tcrc, tx_byte);
          end
          next_q.tidx = q.tidx + 9'h001;
          if (q.tidx == fill_end + 9'h001) begin
            next_q.tidx = 9'h000;
            next_q.rx_cnt = 9'h000;
            next_q.sil = 9'h000;
            next_q.wait_cnt = 16'h0000;
            if (!q.master) begin
              next_q.st = mb_frame_pkg::ST_IDLE;
            end else if (q.req_addr == 16'h0000) begin
              next_q.st = mb_frame_pkg::ST_IDLE;
              next_q.done = 1'b1;
            end else begin
              next_q.st = mb_frame_pkg::ST_WAIT;
            end
          end
        end
      end
      mb_frame_pkg::ST_WAIT: begin
        if (tick && q.rx_cnt == 9'h000) begin
          next_q.wait_cnt = q.wait_cnt + 16'h0001;
        end
        if (good && rx_adr == q.req_addr && (rx_fc & ~mb_frame_pkg::FC_EXC_FLAG) == q.req_fc) begin
          next_q.st = mb_frame_pkg::ST_IDLE;
          next_q.done = 1'b1;
          if (rx_fc[7]) begin
            next_q.err = 1'b1;
            next_q.exc = q.rbuf[3'(hl + 3'h1)];
          end
        end else if (q.rx_cnt == 9'h000 && q.wait_cnt >= q.tmo) begin
          if (q.tries < q.retries) begin
            next_q.tries = q.tries + 4'h1;
            next_q.st = mb_frame_pkg::ST_SEND;
            next_q.tcrc = mb_frame_pkg::CRC_INIT;
          end else begin
            next_q.st = mb_frame_pkg::ST_IDLE;
            next_q.done = 1'b1;
            next_q.err = 1'b1;
          end
        end
      end
      default: next_q.st = mb_frame_pkg::ST_IDLE;
    endcase

    // frame composition
    if (c_go) begin
      if (q.ext) begin
        next_q.tbuf[0] = c_adr[15:8];
        next_q.tbuf[1] = c_adr[7:0];
      end else begin
        next_q.tbuf[0] = c_adr[7:0];
      end
      p = hl;
      next_q.tbuf[p] = c_fc;
      next_q.tfill = 8'h00;
      next_q.tlen = {1'b0, hl} + 4'h1;
      case (c_kind)
        3'h1, 3'h2: begin
          next_q.tbuf[3'(p + 3'h1)] = c_a[15:8];
          next_q.tbuf[3'(p + 3'h2)] = c_a[7:0];
          next_q.tbuf[3'(p + 3'h3)] = c_b[15:8];
          next_q.tbuf[3'(p + 3'h4)] = c_b[7:0];
          next_q.tlen = {1'b0, hl} + 4'h5;
          if (c_kind == 3'h2) begin
            c_cnt = (c_fc == mb_frame_pkg::FC_WR_COILS) ? 8'((c_b + 16'h0007) >> 3) : 8'(c_b << 1);
            next_q.tbuf[3'(p + 3'h5)] = c_cnt;
            next_q.tfill = c_cnt;
            next_q.tlen = {1'b0, hl} + 4'h6;
          end
        end
        3'h3: begin
          next_q.tbuf[3'(p + 3'h1)] = c_cnt;
          next_q.tfill = c_cnt;
          next_q.tlen = {1'b0, hl} + 4'h2;
        end
        3'h4: begin
          next_q.tbuf[p] = c_fc | mb_frame_pkg::FC_EXC_FLAG;
          next_q.tbuf[3'(p + 3'h1)] = exc;
          next_q.tlen = {1'b0, hl} + 4'h2;
        end
        default: ;
      endcase
      next_q.tidx = 9'h000;
      next_q.tcrc = mb_frame_pkg::CRC_INIT;
      next_q.st = mb_frame_pkg::ST_SEND;
    end

    // byte capture, ignored while sending (half duplex)
    if (rx_valid_i && q.st != mb_frame_pkg::ST_SEND && next_q.st != mb_frame_pkg::ST_SEND) begin
      if (next_q.rx_cnt < 9'h008) begin
        next_q.rbuf[next_q.rx_cnt[2:0]] = rx_data_i;
      end
      next_q.rcrc = mb_frame_pkg::crc_step((next_q.rx_cnt == 9'h000) ? mb_frame_pkg::CRC_INIT : q.rcrc, rx_data_i);
      if (next_q.rx_cnt != 9'h1ff) begin
        next_q.rx_cnt = next_q.rx_cnt + 9'h001;
      end
      next_q.sil = 9'h000;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= mb_frame_pkg::ST_IDLE;
      q.div <= mb_frame_pkg::BIT_DIV_RST;
      q.tmo <= mb_frame_pkg::RSP_TIMEOUT_RST;
      q.retries <= mb_frame_pkg::RETRIES_RST;
      q.rcrc <= mb_frame_pkg::CRC_INIT;
      q.tcrc <= mb_frame_pkg::CRC_INIT;
    end else begin
      q <= next_q;
    end
  end
endmodule // modbus_rtu_frame_engine

/* File: verif/mb_frame_props.sv */
/*
  checker on the frame engine's ports: tx framing, crc, exceptions, silence.
  assumes the bench bit divider DIV and a non-zero own station address.
*/
`timescale 1ns/1ns
module mb_frame_props #(parameter int DIV = 4) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i
);
  logic [11:0] quiet;
  logic [15:0] crc;
  logic [3:0] idx;
  logic [7:0] fc;
  logic [7:0] first;
  logic go;
  logic acc;
  assign go = wr_i && addr_i == 8'h00 && wdata_i[2];
  assign acc = tx_valid_o && tx_ready_i;
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // ****************
  // frame tracking
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      quiet <= 12'hfff;
      first <= 8'hff;
    end else begin
      quiet <= rx_valid_i ? 12'h000 : quiet + {11'h000, quiet != 12'hfff};
      if (rx_valid_i && quiet >= 12'(34 * DIV)) first <= rx_data_i;
    end
    crc <= !tx_valid_o ? 16'hffff : (acc ? crc_b(crc, tx_data_o) : crc);
    idx <= !tx_valid_o ? 4'h0 : idx + {3'h0, acc && idx != 4'hf};
    if (acc && idx == 4'h1) fc <= tx_data_o;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
  a_hold: assert property (p_hold) else $error("tx byte changed before accept");
  property p_eof; $rose(tx_valid_o) |-> $past(go) || quiet >= 12'(34 * DIV); endproperty
  a_eof: assert property (p_eof) else $error("reply before end of frame silence");
  property p_crc; $fell(tx_valid_o) |-> crc == 16'h0000; endproperty
  a_crc: assert property (p_crc) else $error("tx frame crc residue not zero");
  property p_len; $fell(tx_valid_o) |-> idx >= 4'h4; endproperty
  a_len: assert property (p_len) else $error("tx frame shorter than four bytes");
  property p_exc_len; $fell(tx_valid_o) && fc[7] |-> idx == 4'h5; endproperty
  a_exc_len: assert property (p_exc_len) else $error("exception frame length wrong");
  property p_exc_code; acc && idx == 4'h2 && fc[7] |-> tx_data_o inside {[8'h01:8'h07]}; endproperty
  a_exc_code: assert property (p_exc_code) else $error("exception code out of range");
  property p_bcast; $rose(tx_valid_o) && !$past(go) |-> first != 8'h00; endproperty
  a_bcast: assert property (p_bcast) else $error("reply to a broadcast");
  property p_rst; disable iff (1'b0) rst_i |=> !tx_valid_o && rdata_o == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  cover property ($fell(tx_valid_o) && fc[7]);
  cover property ($rose(tx_valid_o) && $past(go));
  cover property (tx_valid_o && !tx_ready_i);
endmodule // mb_frame_props

/* File: verif/mb_line_model.sv */
/*
  remote station on the byte side of the serial line: sends frames, collects replies.
  assumes the engine's uart handshake on the same clock.
*/
`timescale 1ns/1ns
module mb_line_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  int frames = 0;
  logic was;
  function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  function automatic logic [15:0] resid();
    logic [15:0] c;
    c = 16'hffff;
    foreach (got[i]) c = crc_b(c, got[i]);
    return c;
  endfunction
  // ****************
  // line behaviour
  // ****************
  initial begin
    rx_data_o = 8'h00;
    rx_valid_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    if (was && !tx_valid_i) frames++;
    was = tx_valid_i;
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  end
  // bytes first to last, crc low then high, optional crc fault
  task automatic send(input logic [79:0] f, input int n, input logic bad);
    logic [15:0] c;
    logic [7:0] b;
    c = 16'hffff;
    for (int i = 0; i < n + 2; i++) begin
      b = i < n ? f[79 - 8 * i -: 8] : (i == n ? c[7:0] ^ {7'h00, bad} : c[15:8]);
      if (i < n) c = crc_b(c, b);
      @(posedge clk_i);
      rx_data_o <= b;
      rx_valid_o <= 1'b1;
      @(posedge clk_i);
      rx_data_o <= ~b;
      rx_valid_o <= 1'b0;
    end
  endtask
endmodule // mb_line_model

/* File: verif/modbus_rtu_frame_engine_tb.sv */
/*
  bench for the frame engine: register port tasks, slave replies, master jobs.
  assumes the line model as remote station and a bit time of 4 clocks.
*/
`timescale 1ns/1ns
module modbus_rtu_frame_engine_tb;
  logic clk_i, rst_i, wr_i, rd_i, tx_valid_o, rx_valid_i, tx_ready_i, slow;
  logic [7:0] addr_i, rx_data_i, tx_data_o;
  logic [31:0] wdata_i, rdata_o, v;
  logic [39:0] tbl[11];
  logic [47:0] drop[3];
  logic [47:0] rq;
  int mismatches, num_checks, k;
  modbus_rtu_frame_engine uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
  mb_line_model line (.clk_i(clk_i), .slow_i(slow), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i), .tx_ready_o(tx_ready_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ****************
  // tasks
  // ****************
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task complete_run;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task give_up(input logic ok);
    if (!ok) begin
      mismatches++;
      complete_run;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task wait_tx(input int n);
    int j;
    for (j = 0; j < 3000 && line.frames < n; j++) @(posedge clk_i);
    give_up(line.frames >= n);
    #1;
  endtask
  task fchk(input logic [23:0] e);
    check("reply address", {24'h0, line.got[0]}, {24'h0, e[23:16]});
    check("reply function", {24'h0, line.got[1]}, {24'h0, e[15:8]});
    check("reply third byte", {24'h0, line.got[2]}, {24'h0, e[7:0]});
    check("reply crc", {16'h0, line.resid()}, 32'h0);
    line.got.delete();
  endtask
  task job(input logic [7:0] a, input logic [7:0] f);
    wr(mb_frame_pkg::OFS_STATUS, 32'he);
    wr(mb_frame_pkg::OFS_REQ_ADDR, {24'h0, a});
    wr(mb_frame_pkg::OFS_REQ_FC, {24'h0, f});
    wr(mb_frame_pkg::OFS_CTRL, 32'h5);
    v = 32'h0;
    for (k = 0; k < 500 && v[1] !== 1'b1; k++) rd(mb_frame_pkg::OFS_STATUS);
    give_up(v[1] === 1'b1);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    {rst_i, wr_i, rd_i, slow, addr_i, wdata_i, v} = {4'b1000, 8'h00, 64'h0};
    {mismatches, num_checks} = 64'h0;
    tbl = '{40'h0100010101, 40'h0200010201, 40'h0300010302, 40'h0400010402, 40'h05ff000500,
      40'h0612340600, 40'h0800000800, 40'h03007e8303, 40'h0107d18103, 40'h0700018701, 40'h0b00008b01};
    drop = '{48'h050300000001, 48'h090300000001, 48'h000600010007};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(mb_frame_pkg::OFS_BIT_DIV);
    check("bit divider", v, {16'h0, mb_frame_pkg::BIT_DIV_RST});
    wr(mb_frame_pkg::OFS_BIT_DIV, 32'h4);
    wr(mb_frame_pkg::OFS_RSP_TIMEOUT, 32'd50);
    wr(mb_frame_pkg::OFS_OWN_ADDR, 32'h5);
    wr(mb_frame_pkg::OFS_FILL, 32'ha5);
    for (int i = 0; i < 11; i++) begin
      slow = i[0];
      line.send({8'h05, tbl[i][39:32], 16'h0, tbl[i][31:16], 32'h0}, 6, 1'b0);
      wait_tx(i + 1);
      fchk({8'h05, tbl[i][15:0]});
    end
    for (int i = 0; i < 3; i++) begin
      line.send({drop[i], 32'h0}, 6, i == 0);
      repeat (200) @(posedge clk_i);
    end
    check("frames after drops", 32'(line.frames), 32'd11);
    rd(mb_frame_pkg::OFS_EVENT_CNT);
    check("event count", v, 32'd8);
    rd(mb_frame_pkg::OFS_LAST_REQ);
    check("last request", v, 32'h0006_0001);
    wr(mb_frame_pkg::OFS_CTRL, 32'h1);
    wr(mb_frame_pkg::OFS_REQ_START, 32'h100);
    wr(mb_frame_pkg::OFS_REQ_QTY, 32'h1);
    wr(mb_frame_pkg::OFS_RETRIES, 32'h1);
    fork
      job(8'h07, mb_frame_pkg::FC_RD_HOLD);
      begin
        wait_tx(12);
        line.send(80'h07830200000000000000, 3, 1'b0);
      end
    join
    rq = 48'h070301000001;
    for (int i = 0; i < 6; i++) check("request byte", {24'h0, line.got[i]}, {24'h0, rq[47 - 8 * i -: 8]});
    check("request crc", {16'h0, line.resid()}, 32'h0);
    check("exception status", v & 32'hff07, 32'h0206);
    line.got.delete();
    job(8'h07, mb_frame_pkg::FC_EVT_CNT);
    check("attempts", 32'(line.frames), 32'd14);
    check("event counter code", {24'h0, line.got[1]}, 32'h0b);
    check("retry status", v & 32'hff07, 32'h0006);
    job(8'h00, mb_frame_pkg::FC_RD_HOLD);
    check("broadcast read refused", {v[2], 31'(line.frames)}, {1'b1, 31'd14});
    job(8'h00, mb_frame_pkg::FC_WR_REG);
    check("broadcast write", {v[2], 31'(line.frames)}, {1'b0, 31'd15});
    check("broadcast no wait", 32'(k < 60), 32'h1);
    complete_run;
  end
endmodule // modbus_rtu_frame_engine_tb
bind modbus_rtu_frame_engine mb_frame_props #(.DIV(4)) chk (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
  .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i));
